/* File: hdl/gmc_top.sv */
// Purpose: Motorised gate controller with AXI4-Lite registers.
// Assumes: 40 MHz aclk; switch and bus-link inputs are asynchronous.
// Notes:   Contactors, lamp and position bits come from flip-flops.
// What this block does
// - Open or close starts travel unless already going the other way.
// - Travel ends on stop or on the end switch of its direction.
// - Travel runs to an end, but stop halts it at any time.
// - The close contactor is never driven while the safety bar acts.
// - With reopen set, the safety bar sends a closing gate back open.
// - The lamp lights a lead time before a contactor and stays on in travel.
// - In multi-gate mode the cord switches are open and close requests.
// - The local open and close switches are accepted as requests.
// - Remote bus commands act as local ones; end states go back to the bus.
// - Remote open and close are separate bits, each for its direction.
// - Stop, end switches and safety bar read low when operated or broken.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
module gmc_top #(
  parameter int unsigned WARN_CYCLES = gmc_pkg::LEAD_CYCLES
) (
  input  wire logic        aclk,                 // System clock
  input  wire logic        aresetn,              // Sync reset, active low
  input  wire logic [7:0]  s_axil_awaddr,        // Write address
  input  wire logic        s_axil_awvalid,       // Write address valid
  output logic             s_axil_awready,       // Write address ready
  input  wire logic [31:0] s_axil_wdata,         // Write data
  input  wire logic [3:0]  s_axil_wstrb,         // Write byte strobes
  input  wire logic        s_axil_wvalid,        // Write data valid
  output logic             s_axil_wready,        // Write data ready
  output logic [1:0]       s_axil_bresp,         // Write response
  output logic             s_axil_bvalid,        // Write response valid
  input  wire logic        s_axil_bready,        // Write response ready
  input  wire logic [7:0]  s_axil_araddr,        // Read address
  input  wire logic        s_axil_arvalid,       // Read address valid
  output logic             s_axil_arready,       // Read address ready
  output logic [31:0]      s_axil_rdata,         // Read data
  output logic [1:0]       s_axil_rresp,         // Read response
  output logic             s_axil_rvalid,        // Read data valid
  input  wire logic        s_axil_rready,        // Read data ready
  input  wire logic        stop_switch_in,       // Stop, NC
  input  wire logic        open_limit_in,        // Open end switch, NC
  input  wire logic        closed_limit_in,      // Closed end switch, NC
  input  wire logic        safety_bar_in,        // Safety bar, NC
  input  wire logic        local_open_in,        // Gate open switch, NO
  input  wire logic        local_close_in,       // Gate close switch, NO
  input  wire logic        cord_open_in,         // Cord open switch, NO
  input  wire logic        cord_close_in,        // Cord close switch, NO
  input  wire logic        bus_remote_open_cmd,  // Remote open bit
  input  wire logic        bus_remote_close_cmd, // Remote close bit
  output logic             open_contactor,       // Opening motor
  output logic             close_contactor,      // Closing motor
  output logic             warning_light,        // Flashing lamp enable
  output logic             bus_open_state_bit,   // Gate open to bus
  output logic             bus_closed_state_bit, // Gate closed to bus
  output logic             irq                   // Interrupt, level
);
  function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
    sel = (a[7:2] == o[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = sel(a, gmc_pkg::ADDR_CTRL) || sel(a, gmc_pkg::ADDR_CMD) ||
             sel(a, gmc_pkg::ADDR_STATUS) || sel(a, gmc_pkg::ADDR_INT_STAT) ||
             sel(a, gmc_pkg::ADDR_INT_MASK);
  endfunction

  // Input synchronisers
  logic [gmc_pkg::NIN-1:0] pin_raw;
  logic [gmc_pkg::NIN-1:0] pin;

  assign pin_raw = {bus_remote_close_cmd, bus_remote_open_cmd,
                    cord_close_in, cord_open_in, local_close_in, local_open_in,
                    safety_bar_in, closed_limit_in,
                    open_limit_in, stop_switch_in};

  gmc_sync #(.W(gmc_pkg::NIN)) u_sync (
    .aclk(aclk), .aresetn(aresetn), .d(pin_raw), .q(pin));

  gmc_timer_if tif ();
  gmc_lead_timer #(.CYCLES(WARN_CYCLES)) u_timer (
    .aclk(aclk), .aresetn(aresetn), .tif(tif));

  logic                      aw_full, next_aw_full;
  logic [7:0]                aw_addr, next_aw_addr;
  logic                      w_full, next_w_full;
  logic [31:0]               w_data, next_w_data;
  logic [3:0]                w_strb, next_w_strb;
  logic                      bvalid, next_bvalid;
  logic [1:0]                bresp, next_bresp;
  logic                      rvalid, next_rvalid;
  logic [31:0]               rdata, next_rdata;
  logic [1:0]                rresp, next_rresp;
  logic [gmc_pkg::CTRL_W-1:0] ctrl, next_ctrl;
  logic [gmc_pkg::CMD_W-1:0] cmd, next_cmd;
  logic [gmc_pkg::EVT_W-1:0] int_stat, next_int_stat;
  logic [gmc_pkg::EVT_W-1:0] int_mask, next_int_mask;
  logic                      next_irq;
  logic                      do_write;
  logic                      rd_take;
  logic [31:0]               status_word;

  gmc_pkg::gmc_state_t       state, next_state;
  logic [gmc_pkg::EVT_W-1:0] evt;
  logic                      next_open_c, next_close_c, next_warn;
  logic                      stop_act, open_at, closed_at, bar_act;
  logic                      open_req, close_req, reopen;

  assign s_axil_awready = !aw_full;
  assign s_axil_wready  = !w_full;
  assign s_axil_bvalid  = bvalid;
  assign s_axil_bresp   = bresp;
  assign s_axil_arready = !rvalid;
  assign s_axil_rvalid  = rvalid;
  assign s_axil_rdata   = rdata;
  assign s_axil_rresp   = rresp;

  assign do_write = aw_full && w_full && !bvalid;
  assign rd_take  = s_axil_arvalid && !rvalid;

  assign status_word = {14'h0000, pin, 2'h0, warning_light,
                        close_contactor, open_contactor, state};

  // Bus slave next values
  always_comb begin
    next_aw_full  = aw_full;
    next_aw_addr  = aw_addr;
    next_w_full   = w_full;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_rvalid   = rvalid;
    next_rdata    = rdata;
    next_rresp    = rresp;
    next_ctrl     = ctrl;
    next_cmd      = '0;
    next_int_mask = int_mask;
    next_int_stat = int_stat;
    if (s_axil_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axil_wdata;
      next_w_strb = s_axil_wstrb;
    end
    if (bvalid && s_axil_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? gmc_pkg::RESP_OKAY
                                     : gmc_pkg::RESP_SLVERR;
      if (w_strb[0]) begin
        if (sel(aw_addr, gmc_pkg::ADDR_CTRL)) begin
          next_ctrl = w_data[gmc_pkg::CTRL_W-1:0];
        end
        if (sel(aw_addr, gmc_pkg::ADDR_CMD)) begin
          next_cmd = w_data[gmc_pkg::CMD_W-1:0];
        end
        if (sel(aw_addr, gmc_pkg::ADDR_INT_MASK)) begin
          next_int_mask = w_data[gmc_pkg::EVT_W-1:0];
        end
      end
    end
    if (rvalid && s_axil_rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axil_araddr) ? gmc_pkg::RESP_OKAY
                                          : gmc_pkg::RESP_SLVERR;
      next_rdata  = '0;
      if (sel(s_axil_araddr, gmc_pkg::ADDR_CTRL)) begin
        next_rdata[gmc_pkg::CTRL_W-1:0] = ctrl;
      end
      if (sel(s_axil_araddr, gmc_pkg::ADDR_STATUS)) begin
        next_rdata = status_word;
      end
      if (sel(s_axil_araddr, gmc_pkg::ADDR_INT_MASK)) begin
        next_rdata[gmc_pkg::EVT_W-1:0] = int_mask;
      end
      if (sel(s_axil_araddr, gmc_pkg::ADDR_INT_STAT)) begin
        next_rdata[gmc_pkg::EVT_W-1:0] = int_stat;
        next_int_stat = '0;
      end
    end
    // New events win over a clearing read
    next_int_stat = next_int_stat | evt;
    next_irq      = |(next_int_stat & next_int_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full  <= 1'b0;
      aw_addr  <= '0;
      w_full   <= 1'b0;
      w_data   <= '0;
      w_strb   <= '0;
      bvalid   <= 1'b0;
      bresp    <= gmc_pkg::RESP_OKAY;
      rvalid   <= 1'b0;
      rdata    <= '0;
      rresp    <= gmc_pkg::RESP_OKAY;
      ctrl     <= gmc_pkg::CTRL_RESET;
      cmd      <= '0;
      int_stat <= '0;
      int_mask <= gmc_pkg::MASK_RESET;
      irq      <= 1'b0;
    end else begin
      aw_full  <= next_aw_full;
      aw_addr  <= next_aw_addr;
      w_full   <= next_w_full;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      rvalid   <= next_rvalid;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
      ctrl     <= next_ctrl;
      cmd      <= next_cmd;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      irq      <= next_irq;
    end
  end

  // NC contacts read low when operated or broken
  assign stop_act  = !pin[gmc_pkg::IN_STOP] || cmd[gmc_pkg::CMD_STOP];
  assign open_at   = !pin[gmc_pkg::IN_OPEN_LIM];
  assign closed_at = !pin[gmc_pkg::IN_CLOSED_LIM];
  assign bar_act   = !pin[gmc_pkg::IN_SAFETY];
  assign reopen    = ctrl[gmc_pkg::CTRL_REOPEN];

  assign open_req = cmd[gmc_pkg::CMD_OPEN] ||
                    pin[gmc_pkg::IN_REM_OPEN] ||
                    pin[gmc_pkg::IN_LOC_OPEN] ||
                    (ctrl[gmc_pkg::CTRL_MULTI] &&
                     pin[gmc_pkg::IN_CORD_OPEN]);
  assign close_req = cmd[gmc_pkg::CMD_CLOSE] ||
                     pin[gmc_pkg::IN_REM_CLOSE] ||
                     pin[gmc_pkg::IN_LOC_CLOSE] ||
                     (ctrl[gmc_pkg::CTRL_MULTI] &&
                      pin[gmc_pkg::IN_CORD_CLOSE]);

  assign tif.run = (state == gmc_pkg::GMC_WARN_OPEN) ||
                   (state == gmc_pkg::GMC_WARN_CLOSE);

  // Sequencer; other-direction requests are not examined
  always_comb begin
    next_state = state;
    evt        = '0;
    unique case (state)
      gmc_pkg::GMC_IDLE: begin
        if (!stop_act) begin
          if (open_req && !open_at) begin
            next_state = gmc_pkg::GMC_WARN_OPEN;
            evt[gmc_pkg::EVT_START] = 1'b1;
          end else if (close_req && !closed_at && !bar_act) begin
            next_state = gmc_pkg::GMC_WARN_CLOSE;
            evt[gmc_pkg::EVT_START] = 1'b1;
          end
        end
      end
      gmc_pkg::GMC_WARN_OPEN: begin
        if (stop_act) begin
          next_state = gmc_pkg::GMC_IDLE;
          evt[gmc_pkg::EVT_STOP] = 1'b1;
        end else if (open_at) begin
          next_state = gmc_pkg::GMC_IDLE;
        end else if (tif.done) begin
          next_state = gmc_pkg::GMC_OPENING;
        end
      end
      gmc_pkg::GMC_WARN_CLOSE: begin
        if (stop_act) begin
          next_state = gmc_pkg::GMC_IDLE;
          evt[gmc_pkg::EVT_STOP] = 1'b1;
        end else if (bar_act) begin
          next_state = reopen ? gmc_pkg::GMC_WARN_OPEN : gmc_pkg::GMC_IDLE;
          evt[gmc_pkg::EVT_SAFETY] = 1'b1;
        end else if (closed_at) begin
          next_state = gmc_pkg::GMC_IDLE;
        end else if (tif.done) begin
          next_state = gmc_pkg::GMC_CLOSING;
        end
      end
      gmc_pkg::GMC_OPENING: begin
        if (stop_act) begin
          next_state = gmc_pkg::GMC_IDLE;
          evt[gmc_pkg::EVT_STOP] = 1'b1;
        end else if (open_at) begin
          next_state = gmc_pkg::GMC_IDLE;
          evt[gmc_pkg::EVT_OPENED] = 1'b1;
        end
      end
      gmc_pkg::GMC_CLOSING: begin
        if (stop_act) begin
          next_state = gmc_pkg::GMC_IDLE;
          evt[gmc_pkg::EVT_STOP] = 1'b1;
        end else if (bar_act) begin
          next_state = reopen ? gmc_pkg::GMC_WARN_OPEN : gmc_pkg::GMC_IDLE;
          evt[gmc_pkg::EVT_SAFETY] = 1'b1;
        end else if (closed_at) begin
          next_state = gmc_pkg::GMC_IDLE;
          evt[gmc_pkg::EVT_CLOSED] = 1'b1;
        end
      end
      default: next_state = gmc_pkg::GMC_IDLE;
    endcase
    next_open_c  = (next_state == gmc_pkg::GMC_OPENING);
    next_close_c = (next_state == gmc_pkg::GMC_CLOSING) &&
                   !bar_act && !next_open_c;
    next_warn    = (next_state != gmc_pkg::GMC_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state                <= gmc_pkg::GMC_IDLE;
      open_contactor       <= 1'b0;
      close_contactor      <= 1'b0;
      warning_light        <= 1'b0;
      bus_open_state_bit   <= 1'b0;
      bus_closed_state_bit <= 1'b0;
    end else begin
      state                <= next_state;
      open_contactor       <= next_open_c;
      close_contactor      <= next_close_c;
      warning_light        <= next_warn;
      bus_open_state_bit   <= open_at;
      bus_closed_state_bit <= closed_at;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/gmc_pkg.sv */
// Purpose: Shared constants and types of the gate motion controller.
// Assumes: 40 MHz aclk, AXI4-Lite register access.
// Notes:   Register offsets are byte addresses of aligned words.
`default_nettype none
package gmc_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned LEAD_TIME_S = 5;
  localparam int unsigned LEAD_CYCLES = LEAD_TIME_S * CLK_HZ;
  localparam int          TMR_W       = 28;
  localparam int          ADDR_W      = 8;

  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CMD      = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;

  localparam int         CTRL_W      = 2;
  localparam int         CTRL_REOPEN = 0;
  localparam int         CTRL_MULTI  = 1;
  localparam logic [1:0] CTRL_RESET  = 2'h0;

  localparam int CMD_W     = 3;
  localparam int CMD_OPEN  = 0;
  localparam int CMD_CLOSE = 1;
  localparam int CMD_STOP  = 2;

  localparam int         EVT_W      = 5;
  localparam int         EVT_START  = 0;
  localparam int         EVT_STOP   = 1;
  localparam int         EVT_OPENED = 2;
  localparam int         EVT_CLOSED = 3;
  localparam int         EVT_SAFETY = 4;
  localparam logic [4:0] MASK_RESET = 5'h00;

  localparam int NIN           = 10;
  localparam int IN_STOP       = 0;
  localparam int IN_OPEN_LIM   = 1;
  localparam int IN_CLOSED_LIM = 2;
  localparam int IN_SAFETY     = 3;
  localparam int IN_LOC_OPEN   = 4;
  localparam int IN_LOC_CLOSE  = 5;
  localparam int IN_CORD_OPEN  = 6;
  localparam int IN_CORD_CLOSE = 7;
  localparam int IN_REM_OPEN   = 8;
  localparam int IN_REM_CLOSE  = 9;

  localparam int STAT_OPEN_C  = 3;
  localparam int STAT_CLOSE_C = 4;
  localparam int STAT_WARN    = 5;
  localparam int STAT_IN_LSB  = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    GMC_IDLE,
    GMC_WARN_OPEN,
    GMC_WARN_CLOSE,
    GMC_OPENING,
    GMC_CLOSING
  } gmc_state_t;
endpackage
`default_nettype wire

/* File: hdl/gmc_timer_if.sv */
// Purpose: Link between the gate sequencer and its lead timer.
// Assumes: Both ends on aclk.
// Notes:   run is a level; done is high in the last lead cycle.
`default_nettype none
interface gmc_timer_if;
  logic run;
  logic done;
  modport ctl (output run, input done);
  modport tmr (input run, output done);
endinterface
`default_nettype wire

/* File: hdl/gmc_sync.sv */
// Purpose: Two-stage synchroniser for a vector of pin inputs.
// Assumes: Each bit is an independent slow level.
// Notes:   Resets to zero, which reads as operated for NC inputs.
`default_nettype none
module gmc_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,    // System clock
  input  wire logic         aresetn, // Sync reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous inputs
  output var  logic [W-1:0] q        // Synchronised outputs
);
  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/gmc_lead_timer.sv */
// Purpose: Counts the warning lead time while run is held.
// Assumes: CYCLES is at least one.
// Notes:   Clears whenever run drops; done stays high until then.
`default_nettype none
module gmc_lead_timer #(
  parameter int unsigned CYCLES = gmc_pkg::LEAD_CYCLES
) (
  input wire logic aclk,    // System clock
  input wire logic aresetn, // Sync reset, active low
  gmc_timer_if.tmr tif      // Run and done
);
  localparam logic [gmc_pkg::TMR_W-1:0] LAST =
    gmc_pkg::TMR_W'(CYCLES - 1);

  logic [gmc_pkg::TMR_W-1:0] count;
  logic [gmc_pkg::TMR_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (!tif.run) begin
      next_count = '0;
    end else if (count != LAST) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign tif.done = tif.run && (count == LAST);
endmodule
`default_nettype wire

/* File: test/gmc_top_props.sv */
// Purpose: Port-level checks of the gate motion controller.
// Assumes: Bound into every gmc_top instance.
// Notes:   Pin checks allow two sync stages plus one FSM edge.
`default_nettype none
module gmc_top_props #(
  parameter int unsigned WARN_CYCLES = 8
) (
  input wire logic aclk,                 // System clock
  input wire logic aresetn,              // Sync reset, active low
  input wire logic stop_switch_in,       // Stop, NC
  input wire logic open_limit_in,        // Open end switch, NC
  input wire logic closed_limit_in,      // Closed end switch, NC
  input wire logic safety_bar_in,        // Safety bar, NC
  input wire logic open_contactor,       // Opening motor
  input wire logic close_contactor,      // Closing motor
  input wire logic warning_light,        // Lamp
  input wire logic bus_open_state_bit,   // Open to bus
  input wire logic bus_closed_state_bit  // Closed to bus
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int unsigned lead;
  int unsigned next_lead;
  // Lamp-on cycles with both motors off
  always_comb next_lead = (warning_light && !open_contactor &&
                           !close_contactor) ? lead + 1 : 0;
  always_ff @(posedge aclk) lead <= aresetn ? next_lead : 0;

  property p_excl; !(open_contactor && close_contactor); endproperty
  a_excl: assert property (p_excl)
    else $error("both contactors on");
  property p_lamp; open_contactor || close_contactor |-> warning_light;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("motor on without lamp");
  property p_lead;
    $rose(open_contactor || close_contactor) |-> lead == WARN_CYCLES;
  endproperty
  a_lead: assert property (p_lead)
    else $error("lead time wrong");
  property p_stop;
    (!stop_switch_in)[*3] |=> !open_contactor && !close_contactor;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not halt");
  property p_safe; (!safety_bar_in)[*3] |=> !close_contactor; endproperty
  a_safe: assert property (p_safe)
    else $error("closing with safety bar");
  property p_oend; (!open_limit_in)[*3] |=> !open_contactor; endproperty
  a_oend: assert property (p_oend)
    else $error("opening past end");
  property p_cend; (!closed_limit_in)[*3] |=> !close_contactor; endproperty
  a_cend: assert property (p_cend)
    else $error("closing past end");
  property p_obit;
    $past(aresetn, 3) && $past(open_limit_in, 2) |->
      bus_open_state_bit == !$past(open_limit_in, 3);
  endproperty
  a_obit: assert property (p_obit)
    else $error("open state bit wrong");
  property p_cbit;
    (!closed_limit_in)[*3] |=> bus_closed_state_bit;
  endproperty
  a_cbit: assert property (p_cbit)
    else $error("closed state bit wrong");
endmodule

bind gmc_top gmc_top_props #(.WARN_CYCLES(WARN_CYCLES)) gmc_top_props_i (
  .aclk, .aresetn, .stop_switch_in, .open_limit_in, .closed_limit_in,
  .safety_bar_in, .open_contactor, .close_contactor, .warning_light,
  .bus_open_state_bit, .bus_closed_state_bit);
`default_nettype wire

/* File: test/gmc_asi_master.sv */
// Purpose: Gatehouse bus master model sending remote gate commands.
// Assumes: want_* come from the bench; state bits from the gate.
// Notes:   A command drops once its end state is reported back.
`default_nettype none
module gmc_asi_master (
  input  wire logic aclk,       // System clock
  input  wire logic aresetn,    // Sync reset, active low
  input  wire logic want_open,  // Operator open request
  input  wire logic want_close, // Operator close request
  input  wire logic open_bit,   // Gate open report
  input  wire logic closed_bit, // Gate closed report
  output logic      cmd_open,   // Remote open bit
  output logic      cmd_close   // Remote close bit
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge aclk) begin
    cmd_open  <= aresetn && want_open && !open_bit;
    cmd_close <= aresetn && want_close && !closed_bit;
  end
endmodule
`default_nettype wire

/* File: test/gmc_top_test.sv */
// Purpose: Self-checking bench of the gate motion controller.
// Assumes: Lead time shortened to W cycles.
// Notes:   Expected values come from the bench's own reckoning.
`default_nettype none
module gmc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned W = 8;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, seed = 32'd56;
  logic [3:0]  s_axil_wstrb = 4'hF;
  logic [1:0]  s_axil_bresp, s_axil_rresp;
  logic        s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0;
  logic        s_axil_bready = 1'b0, s_axil_arvalid = 1'b0;
  logic        s_axil_rready = 1'b0, s_axil_awready, s_axil_wready;
  logic        s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic        stop_switch_in = 1'b1, open_limit_in = 1'b1;
  logic        closed_limit_in = 1'b1, safety_bar_in = 1'b1;
  logic        local_open_in = 1'b0, local_close_in = 1'b0;
  logic        cord_open_in = 1'b0, cord_close_in = 1'b0;
  logic        want_open = 1'b0, want_close = 1'b0;
  logic        bus_remote_open_cmd, bus_remote_close_cmd, irq;
  logic        open_contactor, close_contactor, warning_light;
  logic        bus_open_state_bit, bus_closed_state_bit;
  int          fails = 0, tests_run = 0, cyc = 0, n, ev;

  always #12.5 aclk = ~aclk;

  gmc_top #(.WARN_CYCLES(W)) gmc_top_i (
    .aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
    .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
    .s_axil_rvalid, .s_axil_rready, .stop_switch_in, .open_limit_in,
    .closed_limit_in, .safety_bar_in, .local_open_in, .local_close_in,
    .cord_open_in, .cord_close_in, .bus_remote_open_cmd,
    .bus_remote_close_cmd, .open_contactor, .close_contactor,
    .warning_light, .bus_open_state_bit, .bus_closed_state_bit, .irq);

  gmc_asi_master gmc_asi_master_i (
    .aclk, .aresetn, .want_open, .want_close,
    .open_bit(bus_open_state_bit), .closed_bit(bus_closed_state_bit),
    .cmd_open(bus_remote_open_cmd), .cmd_close(bus_remote_close_cmd));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = gmc_pkg::RESP_OKAY);
    bit ad = 0, wd = 0;
    @(posedge aclk);
    s_axil_awaddr  <= a;
    s_axil_wdata   <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axil_awready === 1'b1) begin
        ad = 1;
        s_axil_awvalid <= 1'b0;
      end
      if (!wd && s_axil_wready === 1'b1) begin
        wd = 1;
        s_axil_wvalid <= 1'b0;
      end
    end
    s_axil_bready <= 1'b1;
    do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
    chk(s_axil_bresp, er);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er = gmc_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axil_araddr  <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready  <= 1'b1;
    do @(posedge aclk); while (s_axil_arready !== 1'b1);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b0;
    chk(s_axil_rdata, ed);
    chk(s_axil_rresp, er);
  endtask

  task automatic wt(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v) begin
      @(posedge aclk);
      k++;
    end
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axr(gmc_pkg::ADDR_CTRL, 0);
    axr(gmc_pkg::ADDR_INT_MASK, 0);
    axr(gmc_pkg::ADDR_INT_STAT, 0);
    axr(gmc_pkg::ADDR_CMD, 0);
    axr(8'h40, 0, gmc_pkg::RESP_SLVERR);
    axw(8'h40, 32'h1, gmc_pkg::RESP_SLVERR);
    seed = xs(seed);
    axw(gmc_pkg::ADDR_INT_MASK, seed);
    axr(gmc_pkg::ADDR_INT_MASK, seed & 32'h1F);
    axw(gmc_pkg::ADDR_INT_MASK, 32'h1F);
    axw(gmc_pkg::ADDR_CTRL, 32'h3);
    $display("registers test done");
    local_open_in <= 1'b1;
    wt(warning_light, 1'b1, n);
    local_open_in  <= 1'b0;
    local_close_in <= 1'b1;
    wt(open_contactor, 1'b1, n);
    chk(n, W);
    repeat (4) @(posedge aclk);
    chk(close_contactor, 1'b0);
    local_close_in <= 1'b0;
    repeat (3) @(posedge aclk);
    axr(gmc_pkg::ADDR_STATUS, (32'hF << gmc_pkg::STAT_IN_LSB) | 32'h2B);
    open_limit_in <= 1'b0;
    wt(open_contactor, 1'b0, n);
    chk(n, 4);
    chk(warning_light, 1'b0);
    chk(bus_open_state_bit, 1'b1);
    @(posedge aclk);
    chk(irq, 1'b1);
    ev = (1 << gmc_pkg::EVT_START) | (1 << gmc_pkg::EVT_OPENED);
    axr(gmc_pkg::ADDR_INT_STAT, ev);
    axr(gmc_pkg::ADDR_INT_STAT, 0);
    chk(irq, 1'b0);
    $display("local open test done");
    open_limit_in <= 1'b1;
    cord_close_in <= 1'b1;
    wt(close_contactor, 1'b1, n);
    cord_close_in <= 1'b0;
    chk(open_contactor, 1'b0);
    safety_bar_in <= 1'b0;
    wt(close_contactor, 1'b0, n);
    chk(warning_light, 1'b1);
    wt(open_contactor, 1'b1, n);
    chk(n, W);
    stop_switch_in <= 1'b0;
    wt(open_contactor, 1'b0, n);
    chk(n, 4);
    chk(warning_light, 1'b0);
    ev = (1 << gmc_pkg::EVT_START) | (1 << gmc_pkg::EVT_STOP) |
         (1 << gmc_pkg::EVT_SAFETY);
    axr(gmc_pkg::ADDR_INT_STAT, ev);
    stop_switch_in <= 1'b1;
    cord_close_in  <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(warning_light | close_contactor, 1'b0);
    cord_close_in <= 1'b0;
    safety_bar_in <= 1'b1;
    axw(gmc_pkg::ADDR_CTRL, 32'h1);
    cord_open_in <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(warning_light, 1'b0);
    cord_open_in <= 1'b0;
    $display("cord and safety test done");
    want_close <= 1'b1;
    wt(close_contactor, 1'b1, n);
    chk(open_contactor, 1'b0);
    closed_limit_in <= 1'b0;
    wt(close_contactor, 1'b0, n);
    chk(n, 4);
    chk(bus_closed_state_bit, 1'b1);
    want_close      <= 1'b0;
    closed_limit_in <= 1'b1;
    want_open       <= 1'b1;
    wt(warning_light, 1'b1, n);
    want_open <= 1'b0;
    wt(open_contactor, 1'b1, n);
    chk(close_contactor, 1'b0);
    axw(gmc_pkg::ADDR_CMD, 32'h1 << gmc_pkg::CMD_STOP);
    repeat (2) @(posedge aclk);
    chk(open_contactor, 1'b0);
    axw(gmc_pkg::ADDR_CMD, 32'h1 << gmc_pkg::CMD_OPEN);
    wt(open_contactor, 1'b1, n);
    axw(gmc_pkg::ADDR_CMD, 32'h1 << gmc_pkg::CMD_CLOSE);
    repeat (3) @(posedge aclk);
    chk({open_contactor, close_contactor}, 2'b10);
    $display("remote and command test done");
    end_sim();
  end
endmodule
`default_nettype wire
